// ---- rtl/arf_pkg.sv ----
// Constants, register map and field layout of the converter control block.
// Assumes a single 50 MHz clock that also serves as the instruction clock.
package arf_pkg;

    // =========================================================
    // Register byte offsets
    localparam logic [7:0] CTRL_ONE_OFFSET = 8'h00;
    localparam logic [7:0] CONNECT_OFFSET = 8'h04;
    localparam logic [7:0] COMMAND_OFFSET = 8'h08;
    localparam logic [7:0] BUFFER_OFFSET = 8'h0C;
    localparam logic [7:0] STATUS_OFFSET = 8'h10;

    // =========================================================
    // Field positions
    localparam int RES_SELECT_BIT = 10;
    localparam int FORMAT_HI = 9;
    localparam int FORMAT_LO = 8;
    localparam int DIVIDER_HI = 7;
    localparam int CHANNEL_HI = 4;
    localparam int SAMPLE_HI = 12;
    localparam int SAMPLE_LO = 8;
    localparam int START_BIT = 15;
    localparam int BUSY_BIT = 0;
    localparam int DONE_BIT = 1;

    // =========================================================
    // Reset values and writable masks
    localparam logic [15:0] CTRL_ONE_RESET = 16'h0000;
    localparam logic [15:0] CTRL_ONE_MASK = 16'h07FF;
    localparam logic [15:0] CONNECT_RESET = 16'h0000;
    localparam logic [15:0] COMMAND_RESET = 16'h0000;
    localparam logic [15:0] COMMAND_MASK = 16'h1F1F;

    // Implemented connect bits per package variant
    localparam logic [15:0] CONNECT_MASK_SMALL = 16'hFE1F;
    localparam logic [15:0] CONNECT_MASK_MIDDLE = 16'hFE3F;
    localparam logic [15:0] CONNECT_MASK_LARGE = 16'hFFFF;
    localparam int PINS_SMALL = 20;
    localparam int PINS_MIDDLE = 28;

    // =========================================================
    // Result formats
    localparam logic [1:0] FORM_UINT = 2'b00;
    localparam logic [1:0] FORM_SINT = 2'b01;
    localparam logic [1:0] FORM_UFRAC = 2'b10;
    localparam logic [1:0] FORM_SFRAC = 2'b11;

    // =========================================================
    // Timing counts in conversion clock periods
    localparam int DISCHARGE_PERIODS = 1;
    localparam int CONVERT_PERIODS = 14;

    // =========================================================
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        ARF_IDLE = 2'b00,
        ARF_DISCHARGE = 2'b01,
        ARF_SAMPLE = 2'b10,
        ARF_CONVERT = 2'b11
    } arf_state_e;

endpackage : arf_pkg

// ---- rtl/arf_result_pack.sv ----
// Packs a signed conversion code into the selected 16-bit buffer format.
// Assumes the code is already clamped to the range of the resolution.
`timescale 1ns/100ps
module arf_result_pack (
    input wire logic twelve_bit,
    input wire logic [1:0] form,
    input wire logic signed [12:0] code,
    output logic [15:0] word
);

    logic neg;
    logic [11:0] mag12;
    logic [9:0] mag10;

    always_comb begin
        neg = code[12];
        mag12 = code[11:0];
        mag10 = code[9:0];
        word = 16'h0000;
        case (form)
            arf_pkg::FORM_UINT: begin
                if (!neg) begin // [R14]
                    word = twelve_bit ? {4'h0, mag12} : {6'h00, mag10}; // [R12]
                end
            end
            arf_pkg::FORM_SINT: begin
                word = twelve_bit ? {{3{code[12]}}, code} // [R11]
                                  : {{5{code[10]}}, code[10:0]}; // [R11]
            end
            arf_pkg::FORM_UFRAC: begin
                if (!neg) begin // [R14]
                    word = twelve_bit ? {mag12, 4'h0} : {mag10, 6'h00}; // [R13]
                end
            end
            arf_pkg::FORM_SFRAC: begin
                word = twelve_bit ? {code[12], mag12, 3'h0} // [R13]
                                  : {code[10], mag10, 5'h00}; // [R13]
            end
            default: begin
                word = 16'h0000;
            end
        endcase
    end

endmodule : arf_result_pack

// ---- rtl/adc_result_formatter.sv ----
// Converter control: AXI4-Lite registers, conversion clock, sequencer, result buffer.
// Assumes the analog side supplies a signed difference in 12-bit LSB steps.
// Function
// R01 - Connect bit attaches charge unit during conversion
// R02 - Unimplemented channel connect bits read zero
// R03 - Package variant removes bits 8:5 or 8:6
// R04 - Conversion clock period is cycle times divider+1
// R05 - Software allows one period of sample time
// R06 - Software finishes sampling after channel change
// R07 - Holding capacitor discharged before every sample
// R08 - Resolution bit 10 picks 12 or 10 bits
// R09 - Format field bits 9:8 selects buffer format
// R10 - Signed results carry an extra sign bit
// R11 - Signed integer replicates sign into upper bits
// R12 - Unsigned integer right-justified, upper bits zero
// R13 - Fractional formats left-justified with low zeros
// R14 - Negative gives zero unsigned, two's complement signed
// R15 - First code step at one LSB
// R16 - Saturate above 4095, never wrap
// R17 - Format codes 00 uint 01 sint 10 ufrac 11 sfrac
// R18 - Writes to unimplemented connect bits ignored
`timescale 1ns/100ps
module adc_result_formatter #(
    parameter int PACKAGE_PINS = 44,
    parameter int DIFF_WIDTH = 14
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic signed [DIFF_WIDTH-1:0] ANALOG_DIFF,
    output logic HOLD_DISCHARGE,
    output logic SAMPLE_ENABLE,
    output logic CONVERT_ENABLE,
    output logic CHARGE_TIME_MEASURE_UNIT_ENABLE,
    output logic [4:0] CHANNEL_SELECT,
    output logic CONVERSION_CLOCK_TICK
);

    // =========================================================
    // Implemented connect bits
    localparam logic [15:0] CONNECT_MASK =
        (PACKAGE_PINS == arf_pkg::PINS_SMALL) ? arf_pkg::CONNECT_MASK_SMALL : // [R03]
        (PACKAGE_PINS == arf_pkg::PINS_MIDDLE) ? arf_pkg::CONNECT_MASK_MIDDLE : // [R03]
        arf_pkg::CONNECT_MASK_LARGE;
    localparam logic [4:0] DISCH_LAST = 5'(arf_pkg::DISCHARGE_PERIODS - 1);
    localparam logic [4:0] CONV_LAST = 5'(arf_pkg::CONVERT_PERIODS - 1);
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input logic [15:0] mask);
        logic [15:0] val;
        val = old;
        if (strb[0]) begin
            val[7:0] = data[7:0];
        end
        if (strb[1]) begin
            val[15:8] = data[15:8];
        end
        merge = (val & mask) | (old & ~mask);
    endfunction : merge

    // =========================================================
    // Register and bus state
    logic [15:0] ctrl_one, next_ctrl_one;
    logic [15:0] connect, next_connect;
    logic [15:0] command, next_command;
    logic [15:0] buffer, next_buffer;
    logic done, next_done;
    logic aw_held, next_aw_held;
    logic [7:0] aw_addr, next_aw_addr;
    logic w_held, next_w_held;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;
    logic rvalid, next_rvalid;
    logic [31:0] rdata, next_rdata;
    logic [1:0] rresp, next_rresp;
    logic start_pulse;
    // Sequencer state
    arf_pkg::arf_state_e state, next_state;
    logic [7:0] div_cnt, next_div_cnt;
    logic [4:0] period_cnt, next_period_cnt;
    logic finish;
    logic twelve_bit;
    logic [1:0] form;
    logic [7:0] divider;
    logic [4:0] sample_last;
    logic period_tick;
    logic signed [12:0] clamped;
    logic signed [DIFF_WIDTH-1:0] shifted;
    logic [15:0] packed_word;
    assign twelve_bit = ctrl_one[arf_pkg::RES_SELECT_BIT]; // [R08]
    assign form = ctrl_one[arf_pkg::FORMAT_HI:arf_pkg::FORMAT_LO]; // [R09] [R17]
    assign divider = ctrl_one[arf_pkg::DIVIDER_HI:0];
    assign sample_last = (command[arf_pkg::SAMPLE_HI:arf_pkg::SAMPLE_LO] == 5'h00) ? 5'h00
                       : command[arf_pkg::SAMPLE_HI:arf_pkg::SAMPLE_LO] - 5'h01;
    assign period_tick = (state != arf_pkg::ARF_IDLE) && (div_cnt == divider); // [R04]

    // =========================================================
    // Clamp and reduce the analog difference
    logic signed [DIFF_WIDTH-1:0] top_code;
    always_comb begin
        shifted = twelve_bit ? ANALOG_DIFF : (ANALOG_DIFF >>> 2); // [R15]
        top_code = twelve_bit ? DIFF_WIDTH'(4095) : DIFF_WIDTH'(1023);
        clamped = 13'(shifted); // [R10]
        if (shifted > top_code) begin
            clamped = 13'(top_code); // [R16]
        end else if (shifted < -top_code - DIFF_WIDTH'(1)) begin
            clamped = 13'(-top_code - DIFF_WIDTH'(1));
        end
    end
    arf_result_pack u_pack (
        .twelve_bit(twelve_bit),
        .form(form),
        .code(clamped),
        .word(packed_word)
    );

    // =========================================================
    // AXI4-Lite slave and register file
    assign S_AXI_AWREADY = !aw_held && !bvalid;
    assign S_AXI_WREADY = !w_held && !bvalid;
    assign S_AXI_ARREADY = !rvalid;
    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        next_ctrl_one = ctrl_one;
        next_connect = connect;
        next_command = command;
        next_done = done;
        start_pulse = 1'b0;
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            next_aw_held = 1'b1;
            next_aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            next_w_held = 1'b1;
            next_w_data = S_AXI_WDATA;
            next_w_strb = S_AXI_WSTRB;
        end
        if (aw_held && w_held && !bvalid) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = arf_pkg::RESP_OKAY;
            case ({aw_addr[7:2], 2'b00})
                arf_pkg::CTRL_ONE_OFFSET: begin
                    next_ctrl_one = merge(ctrl_one, w_data, w_strb, arf_pkg::CTRL_ONE_MASK);
                end
                arf_pkg::CONNECT_OFFSET: begin
                    next_connect = merge(connect, w_data, w_strb, CONNECT_MASK); // [R18]
                end
                arf_pkg::COMMAND_OFFSET: begin
                    // Channel and sample length frozen while busy
                    if (state == arf_pkg::ARF_IDLE) begin // [R06]
                        next_command = merge(command, w_data, w_strb, arf_pkg::COMMAND_MASK);
                        start_pulse = w_strb[1] && w_data[arf_pkg::START_BIT];
                    end
                end
                arf_pkg::BUFFER_OFFSET: begin
                end
                arf_pkg::STATUS_OFFSET: begin
                    if (w_strb[0] && w_data[arf_pkg::DONE_BIT]) begin
                        next_done = 1'b0;
                    end
                end
                default: begin
                    next_bresp = arf_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (finish) begin
            next_done = 1'b1;
        end
        if (bvalid && S_AXI_BREADY) begin
            next_bvalid = 1'b0;
        end
        if (rvalid && S_AXI_RREADY) begin
            next_rvalid = 1'b0;
        end
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            next_rvalid = 1'b1;
            next_rresp = arf_pkg::RESP_OKAY;
            next_rdata = 32'h0000_0000;
            case ({S_AXI_ARADDR[7:2], 2'b00})
                arf_pkg::CTRL_ONE_OFFSET: next_rdata = {16'h0000, ctrl_one};
                arf_pkg::CONNECT_OFFSET: next_rdata = {16'h0000, connect & CONNECT_MASK}; // [R02]
                arf_pkg::COMMAND_OFFSET: begin
                    next_rdata = {16'h0000, command};
                    next_rdata[arf_pkg::START_BIT] = (state != arf_pkg::ARF_IDLE);
                end
                arf_pkg::BUFFER_OFFSET: next_rdata = {16'h0000, buffer};
                arf_pkg::STATUS_OFFSET: begin
                    next_rdata[arf_pkg::BUSY_BIT] = (state != arf_pkg::ARF_IDLE);
                    next_rdata[arf_pkg::DONE_BIT] = done;
                end
                default: next_rresp = arf_pkg::RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= 2'b00;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= 2'b00;
            ctrl_one <= arf_pkg::CTRL_ONE_RESET;
            connect <= arf_pkg::CONNECT_RESET;
            command <= arf_pkg::COMMAND_RESET;
            done <= 1'b0;
        end else begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            ctrl_one <= next_ctrl_one;
            connect <= next_connect;
            command <= next_command;
            done <= next_done;
        end
    end
    assign S_AXI_BVALID = bvalid;
    assign S_AXI_BRESP = bresp;
    assign S_AXI_RVALID = rvalid;
    assign S_AXI_RDATA = rdata;
    assign S_AXI_RRESP = rresp;

    // =========================================================
    // Conversion sequencer
    always_comb begin
        next_state = state;
        next_div_cnt = period_tick ? 8'h00 : div_cnt + 8'h01; // [R04]
        next_period_cnt = period_cnt;
        next_buffer = buffer;
        finish = 1'b0;
        case (state)
            arf_pkg::ARF_IDLE: begin
                next_div_cnt = 8'h00;
                next_period_cnt = 5'h00;
                if (start_pulse) begin
                    next_state = arf_pkg::ARF_DISCHARGE; // [R07]
                end
            end
            arf_pkg::ARF_DISCHARGE: begin
                if (period_tick) begin
                    next_period_cnt = period_cnt + 5'h01;
                    if (period_cnt == DISCH_LAST) begin
                        next_period_cnt = 5'h00;
                        next_state = arf_pkg::ARF_SAMPLE; // [R07]
                    end
                end
            end
            arf_pkg::ARF_SAMPLE: begin
                if (period_tick) begin
                    next_period_cnt = period_cnt + 5'h01;
                    if (period_cnt == sample_last) begin // [R05]
                        next_period_cnt = 5'h00;
                        next_state = arf_pkg::ARF_CONVERT;
                    end
                end
            end
            arf_pkg::ARF_CONVERT: begin
                if (period_tick) begin
                    next_period_cnt = period_cnt + 5'h01;
                    if (period_cnt == CONV_LAST) begin
                        next_period_cnt = 5'h00;
                        next_state = arf_pkg::ARF_IDLE;
                        next_buffer = packed_word;
                        finish = 1'b1;
                    end
                end
            end
            default: begin
                next_state = arf_pkg::ARF_IDLE;
            end
        endcase
    end
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state <= arf_pkg::ARF_IDLE;
            div_cnt <= 8'h00;
            period_cnt <= 5'h00;
            buffer <= 16'h0000;
        end else begin
            state <= next_state;
            div_cnt <= next_div_cnt;
            period_cnt <= next_period_cnt;
            buffer <= next_buffer;
        end
    end

    // =========================================================
    // Analog side controls
    always_comb begin
        HOLD_DISCHARGE = (state == arf_pkg::ARF_DISCHARGE); // [R07]
        SAMPLE_ENABLE = (state == arf_pkg::ARF_SAMPLE);
        CONVERT_ENABLE = (state == arf_pkg::ARF_CONVERT);
        CHANNEL_SELECT = command[arf_pkg::CHANNEL_HI:0];
        CHARGE_TIME_MEASURE_UNIT_ENABLE = CONVERT_ENABLE && !command[arf_pkg::CHANNEL_HI]
            && (connect[command[3:0]] & CONNECT_MASK[command[3:0]]); // [R01]
        CONVERSION_CLOCK_TICK = period_tick;
    end

endmodule : adc_result_formatter

// ---- tb/arf_checker_asserts.sv ----
// Checker for the conversion phase outputs of the converter control block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module arf_checker (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic HOLD_DISCHARGE,
    input wire logic SAMPLE_ENABLE,
    input wire logic CONVERT_ENABLE,
    input wire logic CHARGE_TIME_MEASURE_UNIT_ENABLE,
    input wire logic [4:0] CHANNEL_SELECT,
    input wire logic CONVERSION_CLOCK_TICK
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    // =========================================================
    // Ticks seen in the convert phase
    logic [4:0] conv_ticks;
    logic [4:0] next_conv_ticks;
    logic busy;
    assign busy = HOLD_DISCHARGE | SAMPLE_ENABLE | CONVERT_ENABLE;
    always_comb begin
        next_conv_ticks = 5'h00;
        if (CONVERT_ENABLE) begin
            next_conv_ticks = conv_ticks + 5'(CONVERSION_CLOCK_TICK);
        end
    end
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            conv_ticks <= 5'h00;
        end else begin
            conv_ticks <= next_conv_ticks;
        end
    end

    // =========================================================
    // Properties
    sequence s_discharge_end;
        HOLD_DISCHARGE && CONVERSION_CLOCK_TICK;
    endsequence
    sequence s_sample_start;
        SAMPLE_ENABLE && !HOLD_DISCHARGE;
    endsequence

    a_unit_in_convert: assert property (
        CHARGE_TIME_MEASURE_UNIT_ENABLE |-> CONVERT_ENABLE) else $error("unit on outside convert");
    a_unit_steady: assert property (
        CONVERT_ENABLE && $past(CONVERT_ENABLE) |-> $stable(CHARGE_TIME_MEASURE_UNIT_ENABLE))
        else $error("unit changed in convert");
    a_tick_in_busy: assert property (
        CONVERSION_CLOCK_TICK |-> busy) else $error("tick while idle");
    a_phase_on_tick: assert property (
        $fell(SAMPLE_ENABLE) && !$past(SYS_RST) |-> $past(CONVERSION_CLOCK_TICK))
        else $error("sample ended off tick");
    a_convert_length: assert property (
        $fell(CONVERT_ENABLE) && !$past(SYS_RST) |-> conv_ticks == 5'h0E)
        else $error("convert length wrong");
    a_discharge_holds: assert property (
        HOLD_DISCHARGE && !CONVERSION_CLOCK_TICK |=> HOLD_DISCHARGE)
        else $error("discharge cut short");
    a_discharge_to_sample: assert property (
        s_discharge_end |=> s_sample_start) else $error("no sample after discharge");
    a_sample_after_dis: assert property (
        $rose(SAMPLE_ENABLE) |-> $past(HOLD_DISCHARGE)) else $error("sample without discharge");
    a_channel_steady: assert property (
        busy && $past(busy) |-> $stable(CHANNEL_SELECT)) else $error("channel changed in busy");
endmodule : arf_checker

// ---- tb/tb_top.sv ----
// Self-checking bench of the converter control block over AXI4-Lite.
// Assumes the 20-pin variant and the register map of the package.
`timescale 1ns/100ps
module tb_top;
    logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic signed [13:0] diff;
    wire logic awready, wready, bvalid, arready, rvalid, dis, smp, cnv, unit, tick;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [4:0] chan;
    int err_count, comparisons, n_tick, n_dis, n_smp, n_cnv, n_unit;
    logic [31:0] rd;
    logic [1:0] rs;
    int vals[6] = '{1, 0, -1, 4100, -5000, 2047};
    logic [7:0] offs[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};

    adc_result_formatter #(.PACKAGE_PINS(20)) DUT (
        .CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .ANALOG_DIFF(diff), .HOLD_DISCHARGE(dis), .SAMPLE_ENABLE(smp),
        .CONVERT_ENABLE(cnv), .CHARGE_TIME_MEASURE_UNIT_ENABLE(unit),
        .CHANNEL_SELECT(chan), .CONVERSION_CLOCK_TICK(tick)
    );

    // =========================================================
    // Clock, phase counters, watchdog
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        n_tick += int'(tick);
        n_dis += int'(dis);
        n_smp += int'(smp);
        n_cnv += int'(cnv);
        n_unit += int'(unit);
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        finish_test();
    end

    // =========================================================
    // Bus and compare tasks
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (awvalid && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge clk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!(arvalid && arready));
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd_reg

    task automatic conv(input logic [15:0] ctl, input int dv, input logic [4:0] ch,
                        input logic [4:0] ns);
        wr(arf_pkg::CTRL_ONE_OFFSET, ctl, rs);
        diff <= 14'(dv);
        n_tick = 0;
        n_dis = 0;
        n_smp = 0;
        n_cnv = 0;
        n_unit = 0;
        wr(arf_pkg::COMMAND_OFFSET, {1'b1, 2'h0, ns, 3'h0, ch}, rs);
        wr(arf_pkg::COMMAND_OFFSET, {1'b1, 2'h0, ns, 3'h0, ch ^ 5'h03}, rs);
        rd = 32'h0000_0000;
        while (!rd[1]) rd_reg(arf_pkg::STATUS_OFFSET, rd, rs);
        check(34'(chan), 34'(ch));
        wr(arf_pkg::STATUS_OFFSET, 16'h0002, rs);
    endtask : conv

    task automatic finish_test();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    // =========================================================
    // Tests
    initial begin
        rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0000_0000;
        wstrb = 4'hF;
        diff = 14'h0000;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        foreach (offs[i]) begin
            rd_reg(offs[i], rd, rs);
            check({rs, rd}, 34'h0_0000_0000);
        end
        // Unmapped place
        rd_reg(8'h14, rd, rs);
        check({rs, rd}, {arf_pkg::RESP_SLVERR, 32'h0000_0000});
        wr(8'h14, 16'hFFFF, rs);
        check(34'(rs), 34'(arf_pkg::RESP_SLVERR));
        // Connect bits of absent channels stay zero
        wr(arf_pkg::CONNECT_OFFSET, 16'hFFFF, rs);
        rd_reg(arf_pkg::CONNECT_OFFSET, rd, rs);
        check({rs, rd}, {18'h0_0000, 16'hFFFF & ~16'h01E0});
        wr(arf_pkg::CONNECT_OFFSET, 16'h0030, rs);
        // Divider 3, two sample periods, channel 4 connected
        conv(16'h0403, 100, 5'h04, 5'h02);
        check(34'(n_tick), 34'(1 + 2 + 14));
        check(34'(n_dis), 34'(4));
        check(34'(n_smp), 34'(2 * 4));
        check(34'(n_cnv), 34'(14 * 4));
        check(34'(n_unit), 34'(14 * 4));
        rd_reg(arf_pkg::BUFFER_OFFSET, rd, rs);
        check({rs, rd}, 34'h0_0000_0064);
        // Channel 5 is absent, its write was dropped
        conv(16'h0403, 100, 5'h05, 5'h01);
        check(34'(n_unit), 34'(0));
        // Every resolution, format and edge value
        for (int tw = 0; tw < 2; tw++) begin
            for (int f = 0; f < 4; f++) begin
                foreach (vals[k]) begin
                    conv({5'h00, 1'(tw), 2'(f), 8'h00}, vals[k], 5'h00, 5'h01);
                    rd_reg(arf_pkg::BUFFER_OFFSET, rd, rs);
                    check({rs, rd}, {18'h0_0000, fmt(1'(tw), 2'(f), vals[k])});
                end
            end
        end
        finish_test();
    end

    function automatic logic [15:0] fmt(input logic tw, input logic [1:0] f, input int v);
        int d;
        d = tw ? v : v >>> 2;
        if (tw) d = (d > 4095) ? 4095 : ((d < -4096) ? -4096 : d);
        else d = (d > 1023) ? 1023 : ((d < -1024) ? -1024 : d);
        case (f)
            2'h0: return (d < 0) ? 16'h0000 : 16'(d);
            2'h1: return 16'(d);
            2'h2: return (d < 0) ? 16'h0000 : 16'(tw ? d * 16 : d * 64);
            default: return tw ? {d[31], d[11:0], 3'h0} : {d[31], d[9:0], 5'h00};
        endcase
    endfunction : fmt
endmodule : tb_top

bind adc_result_formatter arf_checker u_chk (
    .CLK(CLK), .SYS_RST(SYS_RST), .HOLD_DISCHARGE(HOLD_DISCHARGE),
    .SAMPLE_ENABLE(SAMPLE_ENABLE), .CONVERT_ENABLE(CONVERT_ENABLE),
    .CHARGE_TIME_MEASURE_UNIT_ENABLE(CHARGE_TIME_MEASURE_UNIT_ENABLE),
    .CHANNEL_SELECT(CHANNEL_SELECT), .CONVERSION_CLOCK_TICK(CONVERSION_CLOCK_TICK)
);
